// file: rtl/tmtr_defs.svh
// Register offsets, field positions, reset values and timing counts for the touch mode/report block.
// Assumes byte addressing on a 32-bit APB with one register per aligned word.
`ifndef TMTR_DEFS_SVH
`define TMTR_DEFS_SVH

`define TMTR_CTRL        12'h000
`define TMTR_STATUS      12'h004
`define TMTR_PREV_CYCLE  12'h008
`define TMTR_XFER_CFG    12'h00C
`define TMTR_XFER_DIV    12'h010
`define TMTR_RATE_A      12'h014
`define TMTR_RATE_B      12'h018
`define TMTR_TIMEOUT     12'h01C
`define TMTR_MATRIX      12'h020
`define TMTR_RESOLUTION  12'h024
`define TMTR_RX2TX       12'h028
`define TMTR_RELATIVE    12'h02C
`define TMTR_RX_MAP      12'h030
`define TMTR_TX_MAP      12'h040
`define TMTR_ACTIVE      12'h050
`define TMTR_FINGER      12'h080

`define TMTR_RX_MAP_WORDS 4
`define TMTR_TX_MAP_WORDS 3
`define TMTR_ROWS         10
`define TMTR_COLS         15
`define TMTR_FINGERS      5
`define TMTR_FINGER_STEP  8

`define TMTR_CTRL_MANUAL   0
`define TMTR_CTRL_RESEED   4
`define TMTR_STAT_MISSED   8
`define TMTR_STAT_OVERFLOW 9

`define TMTR_RST_XFER     16'h0347
`define TMTR_RST_RATE_A   32'h0A0A_0A0A
`define TMTR_RST_RATE_B   8'h0A
`define TMTR_RST_TIMEOUT  32'h0A0A_0A0A
`define TMTR_RST_MATRIX   19'h5_0A0F
`define TMTR_RST_RES      32'h0800_0800

`define TMTR_CLK_PERIOD_NS 20
`define TMTR_MS_NS         1000000
`define TMTR_SEC_MS        10'd1000
`define TMTR_BASE_MHZ      6'd16
`define TMTR_CLK_MHZ       6'd50
`define TMTR_TMO_NEVER     8'hFF
`define TMTR_LP1_UNIT_S    16'd20
`define TMTR_CHARGE_UP_LENGTH_LIN_MAX 4'd4

`endif

// file: rtl/tmtr_pkg.sv
// Types for the touch mode/report block.
// Constants live in tmtr_defs.svh.
package tmtr_pkg;

  typedef enum logic [4:0] {
    M_ACTIVE     = 5'b0_0001,
    M_IDLE_TOUCH = 5'b0_0010,
    M_IDLE       = 5'b0_0100,
    M_LP1        = 5'b0_1000,
    M_LP2        = 5'b1_0000
  } tmtr_mode_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_SCAN = 2'b10
  } tmtr_scan_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] x_frac;
    logic [15:0] y_frac;
  } tmtr_pos_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] strength;
    logic [7:0]  area;
  } tmtr_finger_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  col;
    logic [3:0]  row;
    logic [2:0]  finger;
    logic [15:0] delta;
  } tmtr_chan_t;

endpackage

// file: rtl/tmtr_top.sv
// Touch controller mode sequencing, scan ordering and per-finger trackpad report, APB register access.
// Assumes the sensing front end and position engine run on clk_i and feed results back in the same domain.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "tmtr_defs.svh"

module tmtr_top #(
  parameter int MS_CYCLES = `TMTR_MS_NS / `TMTR_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                                  clk_i,
  input  wire logic                                  rst_n_i,
  // APB slave
  input  wire logic                                  psel_i,
  input  wire logic                                  penable_i,
  input  wire logic                                  pwrite_i,
  input  wire logic [11:0]                           paddr_i,
  input  wire logic [31:0]                           pwdata_i,
  output logic                                       pready_o,
  output logic [31:0]                                prdata_o,
  output logic                                       pslverr_o,
  // Sensing front end
  output logic                                       sense_start_o,
  output logic                                       scan_valid_o,
  output logic [7:0]                                 scan_rx_o,
  output logic [7:0]                                 scan_tx_o,
  output logic [15:0]                                rx_as_tx_o,
  output logic                                       xfer_tick_o,
  output logic                                       reseed_o,
  output logic                                       ref_track_o,
  input  wire tmtr_pkg::tmtr_chan_t                  chan_i,
  input  wire logic                                  sense_done_i,
  // Position engine, one record per finger slot
  input  wire tmtr_pkg::tmtr_pos_t [`TMTR_FINGERS-1:0] pos_i
);

  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  typedef struct packed {
    logic                                 pready;
    logic [31:0]                          prdata;
    logic                                 pslverr;
    logic                                 manual;
    logic                                 ref_track;
    logic [2:0]                           mode_sel;
    logic                                 reseed;
    logic [15:0]                          xfer_cfg;
    logic [31:0]                          rate_a;
    logic [7:0]                           rate_b;
    logic [31:0]                          timeout;
    logic [18:0]                          matrix;
    logic [31:0]                          resolution;
    logic [15:0]                          rx2tx;
    logic [15:0][7:0]                     rx_map;
    logic [11:0][7:0]                     tx_map;
    logic [`TMTR_ROWS-1:0][`TMTR_COLS-1:0] active;
    logic [15:0]                          ms_div;
    logic [5:0]                           phase;
    logic [23:0]                          xfer_cnt;
    logic                                 xfer_tick;
    logic [9:0]                           sec_ms;
    logic [15:0]                          sec_cnt;
    logic [7:0]                           cyc_ms;
    logic                                 done_seen;
    logic                                 cycle_start;
    tmtr_pkg::tmtr_mode_t                 mode;
    logic [15:0]                          prev_cycle;
    logic                                 missed;
    logic                                 overflow;
    logic [2:0]                           nfingers;
    logic [15:0]                          rel_x;
    logic [15:0]                          rel_y;
    tmtr_pkg::tmtr_finger_t [`TMTR_FINGERS-1:0] finger;
    logic [`TMTR_FINGERS-1:0][15:0]       acc_str;
    logic [`TMTR_FINGERS-1:0][7:0]        acc_area;
    tmtr_pkg::tmtr_scan_t                 scan;
    logic [3:0]                           col;
    logic [3:0]                           row;
    logic                                 scan_valid;
    logic [7:0]                           scan_rx;
    logic [7:0]                           scan_tx;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [15:0] len_term(input logic [3:0] s);
    len_term = (s <= `TMTR_CHARGE_UP_LENGTH_LIN_MAX) ? {12'h000, s} : (16'h0001 << (s - 4'd2));
  endfunction

  function automatic logic [2:0] mode_index(input tmtr_pkg::tmtr_mode_t m);
    case (m)
      tmtr_pkg::M_ACTIVE:     mode_index = 3'd0;
      tmtr_pkg::M_IDLE_TOUCH: mode_index = 3'd1;
      tmtr_pkg::M_IDLE:       mode_index = 3'd2;
      tmtr_pkg::M_LP1:        mode_index = 3'd3;
      tmtr_pkg::M_LP2:        mode_index = 3'd4;
      default:                mode_index = 3'd0;
    endcase
  endfunction

  function automatic tmtr_pkg::tmtr_mode_t index_mode(input logic [2:0] i);
    case (i)
      3'd1:    index_mode = tmtr_pkg::M_IDLE_TOUCH;
      3'd2:    index_mode = tmtr_pkg::M_IDLE;
      3'd3:    index_mode = tmtr_pkg::M_LP1;
      3'd4:    index_mode = tmtr_pkg::M_LP2;
      default: index_mode = tmtr_pkg::M_ACTIVE;
    endcase
  endfunction

  logic        apb_acc;
  logic        ms_tick;
  logic        base_tick;
  logic [23:0] xfer_div;
  logic [7:0]  cyc_target;
  logic [7:0]  tmo_set;
  logic [15:0] tmo_target;
  logic        expired;
  logic        cycle_end;
  logic [3:0]  tot_rx;
  logic [3:0]  tot_tx;
  logic [2:0]  max_touch;
  logic [11:0] off;
  logic [2:0]  cnt;
  logic [2:0]  only;
  logic [2:0]  prev_only;
  logic [31:0] prod_x;
  logic [31:0] prod_y;
  logic [15:0] new_x;
  logic [15:0] new_y;
  logic        in_rect;
  logic        ch_ok;

  always_comb begin
    d           = q;
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;
    d.reseed    = 1'b0;
    d.xfer_tick = 1'b0;
    d.cycle_start = 1'b0;
    d.scan_valid  = 1'b0;
    tot_rx      = q.matrix[3:0];
    tot_tx      = q.matrix[11:8];
    max_touch   = q.matrix[18:16];
    apb_acc     = psel_i & penable_i & ~q.pready;
    off         = paddr_i - `TMTR_FINGER;
    cnt         = 3'd0;
    only        = 3'd0;
    prev_only   = 3'd0;
    prod_x      = 32'h0000_0000;
    prod_y      = 32'h0000_0000;
    new_x       = 16'h0000;
    new_y       = 16'h0000;

    // Base clock and transfer strobe; 16 MHz enable from 50 MHz by phase accumulation
    // One spare bit so the sum cannot wrap past the compare
    base_tick = ({1'b0, q.phase} + {1'b0, `TMTR_BASE_MHZ}) >= {1'b0, `TMTR_CLK_MHZ};
    d.phase   = base_tick ? q.phase + `TMTR_BASE_MHZ - `TMTR_CLK_MHZ : q.phase + `TMTR_BASE_MHZ;
    xfer_div  = {8'h00, 16'd2 + len_term(q.xfer_cfg[7:4]) + len_term(q.xfer_cfg[11:8])
                + {12'h000, q.xfer_cfg[15:12]}} << (3'd7 - q.xfer_cfg[2:0]);
    if (base_tick) begin
      if (q.xfer_cnt >= xfer_div - 24'd1) begin
        d.xfer_cnt  = 24'd0;
        d.xfer_tick = 1'b1;
      end else begin
        d.xfer_cnt = q.xfer_cnt + 24'd1;
      end
    end

    // Millisecond and second time base
    ms_tick  = (q.ms_div == MS_LAST);
    d.ms_div = ms_tick ? 16'h0000 : q.ms_div + 16'h0001;
    if (ms_tick) begin
      if (q.sec_ms == `TMTR_SEC_MS - 10'd1) begin
        d.sec_ms  = 10'd0;
        d.sec_cnt = (q.sec_cnt == 16'hFFFF) ? q.sec_cnt : q.sec_cnt + 16'h0001;
      end else begin
        d.sec_ms = q.sec_ms + 10'd1;
      end
      if (q.cyc_ms != 8'hFF) begin
        d.cyc_ms = q.cyc_ms + 8'h01;
      end
    end

    // Per-mode cycle time and timeout
    case (q.mode)
      tmtr_pkg::M_ACTIVE:     begin cyc_target = q.rate_a[7:0];   tmo_set = q.timeout[7:0];   end
      tmtr_pkg::M_IDLE_TOUCH: begin cyc_target = q.rate_a[15:8];  tmo_set = q.timeout[15:8];  end
      tmtr_pkg::M_IDLE:       begin cyc_target = q.rate_a[23:16]; tmo_set = q.timeout[23:16]; end
      tmtr_pkg::M_LP1:        begin cyc_target = q.rate_a[31:24]; tmo_set = q.timeout[31:24]; end
      default:                begin cyc_target = q.rate_b;        tmo_set = `TMTR_TMO_NEVER;  end
    endcase
    tmo_target = (q.mode == tmtr_pkg::M_LP1) ? 16'(tmo_set * `TMTR_LP1_UNIT_S) : {8'h00, tmo_set};
    expired    = (tmo_set != `TMTR_TMO_NEVER) && (q.sec_cnt >= tmo_target);

    // Channel accumulation into finger slots
    in_rect = (chan_i.col < tot_rx) && (chan_i.row < tot_tx) && (chan_i.row < 4'(`TMTR_ROWS));
    ch_ok   = chan_i.valid && in_rect && q.active[chan_i.row][chan_i.col];
    if (sense_done_i) begin
      d.done_seen = 1'b1;
    end
    for (int i = 0; i < `TMTR_FINGERS; i++) begin
      if (ch_ok && chan_i.finger == 3'(i + 1)) begin
        d.acc_str[i]  = q.acc_str[i] + chan_i.delta;
        d.acc_area[i] = q.acc_area[i] + 8'h01;
      end
    end

    // Cycle end: processing done and cycle time reached
    cycle_end = q.done_seen && (q.cyc_ms >= cyc_target) && (q.scan == tmtr_pkg::S_IDLE);
    if (cycle_end) begin
      d.prev_cycle = {8'h00, q.cyc_ms};
      if (q.cyc_ms > cyc_target) begin
        d.missed = 1'b1;
      end
      d.done_seen   = 1'b0;
      d.cyc_ms      = 8'h00;
      d.cycle_start = 1'b1;
      d.acc_str     = '0;
      d.acc_area    = '0;
      for (int i = 0; i < `TMTR_FINGERS; i++) begin
        if (pos_i[i].valid) begin
          cnt  = cnt + 3'd1;
          only = 3'(i);
        end
        if (q.finger[i].area != 8'h00) begin
          prev_only = 3'(i);
        end
      end
      d.nfingers = cnt;
      d.overflow = cnt > max_touch;
      for (int i = 0; i < `TMTR_FINGERS; i++) begin
        prod_x = pos_i[i].x_frac * q.resolution[15:0];
        prod_y = pos_i[i].y_frac * q.resolution[31:16];
        d.finger[i].strength = pos_i[i].valid ? q.acc_str[i] : 16'h0000;
        d.finger[i].area     = pos_i[i].valid ? q.acc_area[i] : 8'h00;
        d.finger[i].x        = (pos_i[i].valid && !(cnt > max_touch)) ? prod_x[31:16] : 16'h0000;
        d.finger[i].y        = (pos_i[i].valid && !(cnt > max_touch)) ? prod_y[31:16] : 16'h0000;
        if (3'(i) == only) begin
          new_x = prod_x[31:16];
          new_y = prod_y[31:16];
        end
      end
      // Movement only across two one-finger cycles in the same slot
      if (cnt == 3'd1 && q.nfingers == 3'd1 && prev_only == only && !(cnt > max_touch)) begin
        d.rel_x = new_x - q.finger[only].x;
        d.rel_y = new_y - q.finger[only].y;
      end else begin
        d.rel_x = 16'h0000;
        d.rel_y = 16'h0000;
      end

      // Mode sequencing
      if (q.manual) begin
        d.mode = index_mode(q.mode_sel);
      end else begin
        case (q.mode)
          tmtr_pkg::M_ACTIVE:     if (cnt != 3'd0) d.sec_cnt = 16'h0000;
                                  else if (expired) d.mode = tmtr_pkg::M_IDLE_TOUCH;
          tmtr_pkg::M_IDLE_TOUCH: if (d.rel_x != 16'h0000 || d.rel_y != 16'h0000) d.mode = tmtr_pkg::M_ACTIVE;
                                  else if (expired) d.mode = tmtr_pkg::M_IDLE;
          tmtr_pkg::M_IDLE:       if (cnt != 3'd0) d.mode = tmtr_pkg::M_ACTIVE;
                                  else if (expired) d.mode = tmtr_pkg::M_LP1;
          tmtr_pkg::M_LP1:        if (cnt != 3'd0) d.mode = tmtr_pkg::M_ACTIVE;
                                  else if (expired) d.mode = tmtr_pkg::M_LP2;
          tmtr_pkg::M_LP2:        if (cnt != 3'd0) d.mode = tmtr_pkg::M_ACTIVE;
          default:                d.mode = tmtr_pkg::M_ACTIVE;
        endcase
      end
      if (d.mode != q.mode) begin
        d.sec_cnt = 16'h0000;
        d.sec_ms  = 10'd0;
      end
    end

    // Scan sequencer: walks the rectangle, skips switched-off channels
    case (q.scan)
      tmtr_pkg::S_IDLE: begin
        if (q.cycle_start && tot_rx != 4'd0 && tot_tx != 4'd0) begin
          d.scan = tmtr_pkg::S_SCAN;
          d.col  = 4'd0;
          d.row  = 4'd0;
        end
      end
      tmtr_pkg::S_SCAN: begin
        if (q.row < 4'(`TMTR_ROWS) && q.col < 4'(`TMTR_COLS) && q.active[q.row][q.col]) begin
          d.scan_valid = 1'b1;
          d.scan_rx    = q.rx_map[q.col];
          d.scan_tx    = q.tx_map[q.row < 4'd12 ? q.row : 4'd0];
        end
        if (q.col >= tot_rx - 4'd1) begin
          d.col = 4'd0;
          if (q.row >= tot_tx - 4'd1) begin
            d.scan = tmtr_pkg::S_IDLE;
          end else begin
            d.row = q.row + 4'd1;
          end
        end else begin
          d.col = q.col + 4'd1;
        end
      end
      default: d.scan = tmtr_pkg::S_IDLE;
    endcase

    // APB access, one wait state
    if (apb_acc) begin
      d.pready = 1'b1;
      d.prdata = 32'h0000_0000;
      if (pwrite_i) begin
        case (paddr_i)
          `TMTR_CTRL: begin
            d.manual   = pwdata_i[`TMTR_CTRL_MANUAL];
            d.mode_sel = pwdata_i[3:1];
            d.reseed   = pwdata_i[`TMTR_CTRL_RESEED];
          end
          `TMTR_STATUS: begin
            // Write one clears; a miss in this cycle still wins
            if (pwdata_i[`TMTR_STAT_MISSED] && !(cycle_end && q.cyc_ms > cyc_target)) d.missed = 1'b0;
          end
          `TMTR_XFER_CFG:   d.xfer_cfg   = pwdata_i[15:0];
          `TMTR_RATE_A:     d.rate_a     = pwdata_i;
          `TMTR_RATE_B:     d.rate_b     = pwdata_i[7:0];
          `TMTR_TIMEOUT:    d.timeout    = pwdata_i;
          `TMTR_MATRIX:     d.matrix     = {pwdata_i[18:16], 4'h0, pwdata_i[11:8], 4'h0, pwdata_i[3:0]};
          `TMTR_RESOLUTION: d.resolution = pwdata_i;
          `TMTR_RX2TX:      d.rx2tx      = pwdata_i[15:0];
          `TMTR_PREV_CYCLE, `TMTR_XFER_DIV, `TMTR_RELATIVE: ;
          default: begin
            if (paddr_i >= `TMTR_RX_MAP && paddr_i < `TMTR_RX_MAP + 12'(4 * `TMTR_RX_MAP_WORDS)) begin
              d.rx_map[4 * paddr_i[3:2] +: 4] = pwdata_i;
            end else if (paddr_i >= `TMTR_TX_MAP && paddr_i < `TMTR_TX_MAP + 12'(4 * `TMTR_TX_MAP_WORDS)) begin
              d.tx_map[4 * paddr_i[3:2] +: 4] = pwdata_i;
            end else if (paddr_i >= `TMTR_ACTIVE && paddr_i < `TMTR_ACTIVE + 12'(4 * `TMTR_ROWS)) begin
              d.active[4'((paddr_i - `TMTR_ACTIVE) >> 2)] = pwdata_i[`TMTR_COLS-1:0];
            end else if (!(paddr_i >= `TMTR_FINGER && off < 12'(`TMTR_FINGER_STEP * `TMTR_FINGERS))) begin
              d.pslverr = 1'b1;
            end
          end
        endcase
      end else begin
        case (paddr_i)
          `TMTR_CTRL:       d.prdata = {27'h0, 1'b0, q.mode_sel, q.manual};
          `TMTR_STATUS:     d.prdata = {19'h0, q.nfingers, q.overflow, q.missed, 5'h0, mode_index(q.mode)};
          `TMTR_PREV_CYCLE: d.prdata = {16'h0, q.prev_cycle};
          `TMTR_XFER_CFG:   d.prdata = {16'h0, q.xfer_cfg};
          `TMTR_XFER_DIV:   d.prdata = {8'h0, xfer_div};
          `TMTR_RATE_A:     d.prdata = q.rate_a;
          `TMTR_RATE_B:     d.prdata = {24'h0, q.rate_b};
          `TMTR_TIMEOUT:    d.prdata = q.timeout;
          `TMTR_MATRIX:     d.prdata = {13'h0, q.matrix};
          `TMTR_RESOLUTION: d.prdata = q.resolution;
          `TMTR_RX2TX:      d.prdata = {16'h0, q.rx2tx};
          `TMTR_RELATIVE:   d.prdata = {q.rel_y, q.rel_x};
          default: begin
            if (paddr_i >= `TMTR_RX_MAP && paddr_i < `TMTR_RX_MAP + 12'(4 * `TMTR_RX_MAP_WORDS)) begin
              d.prdata = q.rx_map[4 * paddr_i[3:2] +: 4];
            end else if (paddr_i >= `TMTR_TX_MAP && paddr_i < `TMTR_TX_MAP + 12'(4 * `TMTR_TX_MAP_WORDS)) begin
              d.prdata = q.tx_map[4 * paddr_i[3:2] +: 4];
            end else if (paddr_i >= `TMTR_ACTIVE && paddr_i < `TMTR_ACTIVE + 12'(4 * `TMTR_ROWS)) begin
              d.prdata = {17'h0, q.active[4'((paddr_i - `TMTR_ACTIVE) >> 2)]};
            end else if (paddr_i >= `TMTR_FINGER && off < 12'(`TMTR_FINGER_STEP * `TMTR_FINGERS)) begin
              d.prdata = off[2] ? {8'h0, q.finger[off[11:3]].area, q.finger[off[11:3]].strength}
                                : {q.finger[off[11:3]].y, q.finger[off[11:3]].x};
            end else begin
              d.pslverr = 1'b1;
            end
          end
        endcase
      end
    end
    d.ref_track = ~d.manual;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q            <= '0;
      q.xfer_cfg   <= `TMTR_RST_XFER;
      q.rate_a     <= `TMTR_RST_RATE_A;
      q.rate_b     <= `TMTR_RST_RATE_B;
      q.timeout    <= `TMTR_RST_TIMEOUT;
      q.matrix     <= `TMTR_RST_MATRIX;
      q.resolution <= `TMTR_RST_RES;
      q.active     <= '1;
      q.mode       <= tmtr_pkg::M_ACTIVE;
      q.scan       <= tmtr_pkg::S_IDLE;
      q.ref_track  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pready_o      = q.pready;
  assign prdata_o      = q.prdata;
  assign pslverr_o     = q.pslverr;
  assign sense_start_o = q.cycle_start;
  assign scan_valid_o  = q.scan_valid;
  assign scan_rx_o     = q.scan_rx;
  assign scan_tx_o     = q.scan_tx;
  assign rx_as_tx_o    = q.rx2tx;
  assign xfer_tick_o   = q.xfer_tick;
  assign reseed_o      = q.reseed;
  assign ref_track_o   = q.ref_track;

endmodule

// file: verif/tmtr_asserts.sv
// Port checker for the touch mode/report block.
// Assumes a bind onto tmtr_top and one clock domain.
`timescale 1ns/1ps
module tmtr_asserts (
  // Watched ports
  input wire logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [15:0] rx_as_tx_o,
  input wire logic        pready_o, pslverr_o, sense_start_o, xfer_tick_o, reseed_o, ref_track_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  assign take = psel_i && penable_i && !pready_o;
  a_ready_wait: assert property (take |=> pready_o) else $error("access not answered");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready held too long");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_start_pulse: assert property (sense_start_o |=> !sense_start_o) else $error("start pulse too long");
  a_tick_spacing: assert property (xfer_tick_o |=> !xfer_tick_o [*4]) else $error("ticks too close");
  a_manual_track: assert property (take && pwrite_i && paddr_i == 12'h000 |-> ##3 ref_track_o == !$past(pwdata_i[0], 3))
    else $error("reference tracking ignores manual");
  a_reseed_cause: assert property (reseed_o |-> $past(psel_i && pwrite_i && paddr_i == 12'h000 && pwdata_i[4]))
    else $error("reseed without command");
  a_rx2tx_level: assert property (take && pwrite_i && paddr_i == 12'h028 |-> ##3 rx_as_tx_o == $past(pwdata_i[15:0], 3))
    else $error("receive as transmit mismatch");
endmodule
bind tmtr_top tmtr_asserts i_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .rx_as_tx_o, .pready_o, .pslverr_o, .sense_start_o, .xfer_tick_o, .reseed_o, .ref_track_o);

// file: verif/tmtr_front.sv
// Sensing front end stand-in: one finger sample and a done pulse per report cycle.
// Assumes the bench sets the finger count and the processing delay.
`timescale 1ns/1ps
`include "tmtr_defs.svh"
module tmtr_front (
  // Clock, reset and bench controls
  input  wire logic       clk_i, rst_n_i, start_i,
  input  wire logic [2:0] fingers_i,
  input  wire logic [7:0] delay_i,
  // Toward the design
  output tmtr_pkg::tmtr_chan_t                    chan_o,
  output logic                                    done_o,
  output tmtr_pkg::tmtr_pos_t [`TMTR_FINGERS-1:0] pos_o
);
  logic [7:0] cnt_q;
  logic       busy_q;
  // Idle samples clear valid and invert the rest so stale data never looks valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cnt_q, busy_q, done_o, chan_o} <= {8'h00, 1'b1, 1'b0, 28'h0};
    end else begin
      done_o <= busy_q && cnt_q == delay_i;
      cnt_q <= start_i ? 8'h00 : cnt_q + 8'h01;
      busy_q <= start_i || (busy_q && cnt_q != delay_i);
      chan_o <= start_i ? {fingers_i != 3'd0, 4'h0, 4'h0, 3'd1, 16'h0010} : {1'b0, ~chan_o[26:0]};
    end
  end
  for (genvar g = 0; g < `TMTR_FINGERS; g++) begin : g_pos
    assign pos_o[g] = {g < fingers_i, 16'h8000, 16'h4000};
  end
endmodule

// file: verif/tmtr_top_bench.sv
// Self-checking bench for the touch mode/report block.
// Assumes tmtr_front as the sensing front end; 1 ms is 50 clocks.
`timescale 1ns/1ps
`include "tmtr_defs.svh"
module tmtr_top_bench;
  logic        clk_i = 0, rst_n_i = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, start, done, last_err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [2:0]  fingers = 3'd1;
  logic [7:0]  delay = 8'd5;
  int          mismatches = 0, checks_done = 0, cyc = 0;
  tmtr_pkg::tmtr_chan_t chan;
  tmtr_pkg::tmtr_pos_t [`TMTR_FINGERS-1:0] pos;
  logic        tick, sval;
  logic [7:0]  srx, stx;
  logic [15:0] seen = '0;
  int          ticks = 0;
  always #10 clk_i = ~clk_i;
  // Transfer strobes and the last scanned electrode pair
  always @(posedge clk_i) begin
    if (tick) ticks++;
    if (sval) seen <= {stx, srx};
  end
  tmtr_top #(.MS_CYCLES(50)) i_dut (.clk_i, .rst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .sense_start_o(start), .scan_valid_o(sval), .scan_rx_o(srx), .scan_tx_o(stx), .rx_as_tx_o(), .xfer_tick_o(tick),
    .reseed_o(), .ref_track_o(), .chan_i(chan), .sense_done_i(done), .pos_i(pos));
  tmtr_front i_front (.clk_i, .rst_n_i, .start_i(start), .fingers_i(fingers), .delay_i(delay),
    .chan_o(chan), .done_o(done), .pos_o(pos));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wait_rep(input int n);
    repeat (n) @(posedge start);
    @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Ceiling covers the one second timeout run plus margin
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    logic [31:0] tab [8];
    tab = '{32'h0347, 32'h9, 32'h1657, 32'h1B, 32'h0345, 32'h24, 32'h0047, 32'h6};
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(`TMTR_RATE_A, 32'h0A0A_0A0A);
    rd(`TMTR_TIMEOUT, 32'h0A0A_0A0A);
    rd(`TMTR_MATRIX, 32'h0005_0A0F);
    for (int i = 0; i < 8; i += 2) begin
      apb(1'b1, `TMTR_XFER_CFG, tab[i]);
      rd(`TMTR_XFER_DIV, tab[i+1]);
    end
    chk(32'(ticks != 0), 32'h1);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({q[31:1], last_err}, 32'h1);
    // One-channel pad keeps scanning well inside a 1 ms cycle
    apb(1'b1, `TMTR_MATRIX, 32'h0005_0101);
    apb(1'b1, `TMTR_RATE_A, 32'h0101_0101);
    apb(1'b1, `TMTR_RATE_B, 32'h1);
    apb(1'b1, `TMTR_RX_MAP, 32'h0108_0003);
    rd(`TMTR_RX_MAP, 32'h0108_0003);
    apb(1'b1, `TMTR_RX2TX, 32'h30);
    rd(`TMTR_RX2TX, 32'h30);
    wait_rep(3);
    rd(`TMTR_PREV_CYCLE, 32'h1);
    rd(`TMTR_STATUS, 32'h400);
    rd(`TMTR_FINGER, 32'h0200_0400);
    rd(12'h084, 32'h0001_0010);
    rd(12'h08C, 32'h0);
    rd(`TMTR_RELATIVE, 32'h0);
    chk(32'(seen), 32'h0000_0003);
    fingers <= 3'd2;
    wait_rep(2);
    rd(12'h088, 32'h0200_0400);
    apb(1'b1, `TMTR_MATRIX, 32'h0001_0101);
    wait_rep(2);
    rd(`TMTR_STATUS, 32'hA00);
    rd(`TMTR_FINGER, 32'h0);
    apb(1'b1, `TMTR_MATRIX, 32'h0005_0101);
    fingers <= 3'd1;
    delay <= 8'd120;
    wait_rep(2);
    rd(`TMTR_PREV_CYCLE, 32'h2);
    rd(`TMTR_STATUS, 32'h500);
    delay <= 8'd5;
    wait_rep(2);
    apb(1'b1, `TMTR_STATUS, 32'h100);
    rd(`TMTR_STATUS, 32'h400);
    apb(1'b1, `TMTR_ACTIVE, 32'h7FFE);
    wait_rep(2);
    rd(12'h084, 32'h0);
    fingers <= 3'd0;
    apb(1'b1, `TMTR_TIMEOUT, 32'h0A0A_FF01);
    wait_rep(1100);
    rd(`TMTR_STATUS, 32'h1);
    for (int m = 0; m < 5; m++) begin
      apb(1'b1, `TMTR_CTRL, 32'h11 | 32'(m << 1));
      wait_rep(2);
      rd(`TMTR_STATUS, 32'(m));
    end
    print_verdict();
  end
endmodule
